// *** verilog/usb_cmd_pkg.sv ***
package usb_cmd_pkg;

  // word layout: byte 2 carries code or data, byte 1 carries the phase
  localparam int CODE_LSB = 16;
  localparam int PHASE_LSB = 8;

  localparam logic [7:0] PH_CMD = 8'h05;
  localparam logic [7:0] PH_WR = 8'h01;
  localparam logic [7:0] PH_RD = 8'h02;

  localparam logic [7:0] CODE_SET_ADDR = 8'hD0;
  localparam logic [7:0] CODE_CONFIG = 8'hD8;
  localparam logic [7:0] CODE_SET_MODE = 8'hF3;
  localparam logic [7:0] CODE_FRAME = 8'hF5;
  localparam logic [7:0] CODE_TEST = 8'hFD;
  localparam logic [7:0] CODE_DEV_STATUS = 8'hFE;
  localparam logic [7:0] CODE_ERR_CODE = 8'hFF;
  localparam logic [7:0] CODE_ERR_STATUS = 8'hFB;
  localparam logic [7:0] CODE_CLR_BUF = 8'hF2;
  localparam logic [7:0] CODE_VALIDATE = 8'hFA;
  localparam logic [7:0] CODE_EP_LAST = 8'h1F;
  localparam logic [7:0] CODE_SEL_CLR_BASE = 8'h40;
  localparam logic [7:0] CODE_SEL_CLR_LAST = 8'h5F;

  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_EP = 5'h00;

  typedef enum logic [3:0] {
    CLS_BAD = 4'h0,
    CLS_DEV_WR = 4'h1,
    CLS_FRAME = 4'h2,
    CLS_TEST = 4'h3,
    CLS_DEV_STATUS = 4'h4,
    CLS_ERR_CODE = 4'h5,
    CLS_ERR_STATUS = 4'h6,
    CLS_SEL = 4'h7,
    CLS_SEL_CLR = 4'h8,
    CLS_CLR_BUF = 4'h9,
    CLS_VALIDATE = 4'hA
  } cmd_class_t;

  typedef enum logic [3:0] {
    ACT_NONE = 4'h0,
    ACT_SET_ADDR = 4'h1,
    ACT_CONFIG = 4'h2,
    ACT_SET_MODE = 4'h3,
    ACT_SET_DEV_STATUS = 4'h4,
    ACT_SELECT = 4'h5,
    ACT_SEL_CLR_INT = 4'h6,
    ACT_SET_EP_STATUS = 4'h7,
    ACT_CLR_BUF = 4'h8,
    ACT_VALIDATE = 4'h9
  } act_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OPEN = 2'b10
  } cmd_state_t;

  typedef struct packed {
    logic valid;
    act_kind_t kind;
    logic [4:0] ep;
    logic [7:0] data;
  } action_t;

  typedef struct packed {
    logic [15:0] frame;
    logic [15:0] test;
    logic [7:0] dev_status;
    logic [7:0] err_code;
    logic [7:0] err_status;
    logic [7:0] ep_info;
    logic [7:0] clr_buf_info;
  } engine_view_t;

endpackage : usb_cmd_pkg

// *** verilog/usb_code_class.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_code_class (
  input wire logic [7:0] code,
  output usb_cmd_pkg::cmd_class_t cls
);

  always_comb begin
    if (code <= usb_cmd_pkg::CODE_EP_LAST) begin
      cls = usb_cmd_pkg::CLS_SEL;
    end else if (code >= usb_cmd_pkg::CODE_SEL_CLR_BASE &&
                 code <= usb_cmd_pkg::CODE_SEL_CLR_LAST) begin
      cls = usb_cmd_pkg::CLS_SEL_CLR;
    end else begin
      case (code)
        usb_cmd_pkg::CODE_SET_ADDR, usb_cmd_pkg::CODE_CONFIG,
        usb_cmd_pkg::CODE_SET_MODE: cls = usb_cmd_pkg::CLS_DEV_WR;
        usb_cmd_pkg::CODE_FRAME: cls = usb_cmd_pkg::CLS_FRAME;
        usb_cmd_pkg::CODE_TEST: cls = usb_cmd_pkg::CLS_TEST;
        usb_cmd_pkg::CODE_DEV_STATUS: cls = usb_cmd_pkg::CLS_DEV_STATUS;
        usb_cmd_pkg::CODE_ERR_CODE: cls = usb_cmd_pkg::CLS_ERR_CODE;
        usb_cmd_pkg::CODE_ERR_STATUS: cls = usb_cmd_pkg::CLS_ERR_STATUS;
        usb_cmd_pkg::CODE_CLR_BUF: cls = usb_cmd_pkg::CLS_CLR_BUF;
        usb_cmd_pkg::CODE_VALIDATE: cls = usb_cmd_pkg::CLS_VALIDATE;
        default: cls = usb_cmd_pkg::CLS_BAD;
      endcase
    end
  end

endmodule : usb_code_class
`default_nettype wire

// *** verilog/usb_engine_command_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_engine_command_port (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cmd_word_wr,
  input wire logic [31:0] engine_command_word_reg,
  input wire logic slot_free_clr,
  input wire logic result_ready_clr,
  input wire usb_cmd_pkg::engine_view_t view,
  output logic command_slot_free_flag,
  output logic result_ready_flag,
  output logic [7:0] engine_result_byte_reg,
  output usb_cmd_pkg::action_t action,
  output logic [4:0] selected_ep
);

  typedef struct packed {
    usb_cmd_pkg::cmd_state_t state;
    logic [7:0] code;
    usb_cmd_pkg::cmd_class_t cls;
    logic [1:0] rd_idx;
    logic slot_free;
    logic result_ready;
    logic [7:0] result;
    usb_cmd_pkg::action_t act;
    logic [4:0] sel_ep;
  } port_state_t;

  localparam port_state_t RST_STATE = '{
    state: usb_cmd_pkg::ST_IDLE, code: usb_cmd_pkg::RST_BYTE, cls: usb_cmd_pkg::CLS_BAD,
    rd_idx: usb_cmd_pkg::BYTES_NONE, slot_free: 1'b0, result_ready: 1'b0,
    result: usb_cmd_pkg::RST_BYTE,
    act: '{valid: 1'b0, kind: usb_cmd_pkg::ACT_NONE, ep: usb_cmd_pkg::RST_EP,
           data: usb_cmd_pkg::RST_BYTE},
    sel_ep: usb_cmd_pkg::RST_EP};

  port_state_t state_ff;
  port_state_t nxt_state;

  logic [7:0] w_code;
  logic [7:0] w_phase;
  usb_cmd_pkg::cmd_class_t w_cls;
  logic rd_ok;
  logic wr_ok;

  assign w_code = engine_command_word_reg[usb_cmd_pkg::CODE_LSB +: 8];
  assign w_phase = engine_command_word_reg[usb_cmd_pkg::PHASE_LSB +: 8];

  usb_code_class u_class (
    .code(w_code),
    .cls(w_cls)
  );

  // how many result bytes each command may hand back
  function automatic logic [1:0] read_limit(input usb_cmd_pkg::cmd_class_t c);
    case (c)
      usb_cmd_pkg::CLS_FRAME,
      usb_cmd_pkg::CLS_TEST: read_limit = usb_cmd_pkg::BYTES_TWO;
      usb_cmd_pkg::CLS_DEV_STATUS, usb_cmd_pkg::CLS_ERR_CODE, usb_cmd_pkg::CLS_ERR_STATUS,
      usb_cmd_pkg::CLS_SEL, usb_cmd_pkg::CLS_SEL_CLR,
      usb_cmd_pkg::CLS_CLR_BUF: read_limit = usb_cmd_pkg::BYTES_ONE;
      default: read_limit = usb_cmd_pkg::BYTES_NONE;
    endcase
  endfunction : read_limit

  function automatic logic [7:0] result_for(input usb_cmd_pkg::cmd_class_t c,
                                            input logic [1:0] idx,
                                            input usb_cmd_pkg::engine_view_t v);
    case (c)
      usb_cmd_pkg::CLS_FRAME: result_for = idx[0] ? v.frame[15:8] : v.frame[7:0];
      usb_cmd_pkg::CLS_TEST: result_for = idx[0] ? v.test[15:8] : v.test[7:0];
      usb_cmd_pkg::CLS_DEV_STATUS: result_for = v.dev_status;
      usb_cmd_pkg::CLS_ERR_CODE: result_for = v.err_code;
      usb_cmd_pkg::CLS_ERR_STATUS: result_for = v.err_status;
      usb_cmd_pkg::CLS_SEL, usb_cmd_pkg::CLS_SEL_CLR: result_for = v.ep_info;
      usb_cmd_pkg::CLS_CLR_BUF: result_for = v.clr_buf_info;
      default: result_for = usb_cmd_pkg::RST_BYTE;
    endcase
  endfunction : result_for

  function automatic usb_cmd_pkg::act_kind_t write_kind(input logic [7:0] code,
                                                        input usb_cmd_pkg::cmd_class_t c);
    if (c == usb_cmd_pkg::CLS_SEL_CLR) begin
      write_kind = usb_cmd_pkg::ACT_SET_EP_STATUS;
    end else begin
      case (code)
        usb_cmd_pkg::CODE_SET_ADDR: write_kind = usb_cmd_pkg::ACT_SET_ADDR;
        usb_cmd_pkg::CODE_CONFIG: write_kind = usb_cmd_pkg::ACT_CONFIG;
        usb_cmd_pkg::CODE_SET_MODE: write_kind = usb_cmd_pkg::ACT_SET_MODE;
        usb_cmd_pkg::CODE_DEV_STATUS: write_kind = usb_cmd_pkg::ACT_SET_DEV_STATUS;
        default: write_kind = usb_cmd_pkg::ACT_NONE;
      endcase
    end
  endfunction : write_kind

  // a read phase must repeat the open command's code and stay within its byte count
  assign rd_ok = state_ff.state == usb_cmd_pkg::ST_OPEN && w_code == state_ff.code &&
                 state_ff.rd_idx < read_limit(state_ff.cls);
  // a write phase is legal once, before any read, for write-capable codes
  assign wr_ok = state_ff.state == usb_cmd_pkg::ST_OPEN &&
                 state_ff.rd_idx == usb_cmd_pkg::BYTES_NONE &&
                 write_kind(state_ff.code, state_ff.cls) != usb_cmd_pkg::ACT_NONE;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.act.valid = 1'b0;
    nxt_state.act.kind = usb_cmd_pkg::ACT_NONE;
    if (slot_free_clr) begin
      nxt_state.slot_free = 1'b0;
    end
    if (result_ready_clr) begin
      nxt_state.result_ready = 1'b0;
    end
    if (cmd_word_wr) begin
      case (w_phase)
        usb_cmd_pkg::PH_CMD: begin
          nxt_state.state = usb_cmd_pkg::ST_OPEN;
          nxt_state.code = w_code;
          nxt_state.cls = w_cls;
          nxt_state.rd_idx = usb_cmd_pkg::BYTES_NONE;
          nxt_state.slot_free = 1'b1;
          nxt_state.act.ep = state_ff.sel_ep;
          nxt_state.act.data = usb_cmd_pkg::RST_BYTE;
          case (w_cls)
            usb_cmd_pkg::CLS_SEL, usb_cmd_pkg::CLS_SEL_CLR: begin
              nxt_state.sel_ep = w_code[4:0];
              nxt_state.act.ep = w_code[4:0];
              nxt_state.act.valid = 1'b1;
              nxt_state.act.kind = usb_cmd_pkg::ACT_SELECT;
            end
            usb_cmd_pkg::CLS_CLR_BUF: begin
              nxt_state.act.valid = 1'b1;
              nxt_state.act.kind = usb_cmd_pkg::ACT_CLR_BUF;
            end
            usb_cmd_pkg::CLS_VALIDATE: begin
              nxt_state.act.valid = 1'b1;
              nxt_state.act.kind = usb_cmd_pkg::ACT_VALIDATE;
              nxt_state.state = usb_cmd_pkg::ST_IDLE;
            end
            default: begin
            end
          endcase
        end
        usb_cmd_pkg::PH_WR: begin
          nxt_state.slot_free = 1'b1;
          if (wr_ok) begin
            nxt_state.act.valid = 1'b1;
            nxt_state.act.kind = write_kind(state_ff.code, state_ff.cls);
            nxt_state.act.ep = state_ff.sel_ep;
            nxt_state.act.data = w_code;
            nxt_state.state = usb_cmd_pkg::ST_IDLE;
          end
        end
        usb_cmd_pkg::PH_RD: begin
          if (rd_ok) begin
            nxt_state.result = result_for(state_ff.cls, state_ff.rd_idx, view);
            nxt_state.result_ready = 1'b1;
            nxt_state.rd_idx = state_ff.rd_idx + 2'h1;
            if (state_ff.cls == usb_cmd_pkg::CLS_SEL_CLR) begin
              nxt_state.act.valid = 1'b1;
              nxt_state.act.kind = usb_cmd_pkg::ACT_SEL_CLR_INT;
              nxt_state.act.ep = state_ff.sel_ep;
              nxt_state.act.data = usb_cmd_pkg::RST_BYTE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= RST_STATE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign command_slot_free_flag = state_ff.slot_free;
  assign result_ready_flag = state_ff.result_ready;
  assign engine_result_byte_reg = state_ff.result;
  assign action = state_ff.act;
  assign selected_ep = state_ff.sel_ep;

  logic acc;
  logic rd_go;
  assign acc = clk_en && cmd_word_wr;
  assign rd_go = acc && w_phase == usb_cmd_pkg::PH_RD && rd_ok;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_SLOT_SET: assert property (acc && w_phase != usb_cmd_pkg::PH_RD &&
    (w_phase == usb_cmd_pkg::PH_CMD || w_phase == usb_cmd_pkg::PH_WR) |=> command_slot_free_flag)
    else $error("slot free flag not set after accepted phase");
  AST_READY_SET: assert property (rd_go |=> result_ready_flag)
    else $error("result ready flag not set after read");
  AST_FRAME_ORDER: assert property (rd_go && state_ff.cls == usb_cmd_pkg::CLS_FRAME
    |=> engine_result_byte_reg == ($past(state_ff.rd_idx) == 2'h0 ?
    $past(view.frame[7:0]) : $past(view.frame[15:8])))
    else $error("frame bytes out of order");
  AST_TEST_TWO: assert property (acc && w_phase == usb_cmd_pkg::PH_RD &&
    state_ff.cls == usb_cmd_pkg::CLS_TEST && state_ff.rd_idx == 2'h2 && !result_ready_clr
    |=> $stable(engine_result_byte_reg) && $stable(result_ready_flag))
    else $error("test register gave a third byte");
  AST_STATUS_RD: assert property (rd_go && state_ff.cls == usb_cmd_pkg::CLS_DEV_STATUS
    |=> engine_result_byte_reg == $past(view.dev_status) && !action.valid)
    else $error("device status read wrong");
  AST_ERR_RD: assert property (rd_go &&
    state_ff.cls inside {usb_cmd_pkg::CLS_ERR_CODE, usb_cmd_pkg::CLS_ERR_STATUS} |=>
    engine_result_byte_reg == ($past(state_ff.cls) == usb_cmd_pkg::CLS_ERR_CODE ?
    $past(view.err_code) : $past(view.err_status)))
    else $error("error byte wrong");
  AST_DEV_WRITE: assert property (acc && w_phase == usb_cmd_pkg::PH_WR && wr_ok &&
    state_ff.code == usb_cmd_pkg::CODE_SET_ADDR |=> action.valid &&
    action.kind == usb_cmd_pkg::ACT_SET_ADDR && action.data == $past(w_code))
    else $error("set address write not carried out");
  AST_SELECT: assert property (acc && w_phase == usb_cmd_pkg::PH_CMD &&
    w_code <= usb_cmd_pkg::CODE_EP_LAST |=> action.valid &&
    action.kind == usb_cmd_pkg::ACT_SELECT && selected_ep == $past(w_code[4:0]))
    else $error("endpoint not selected");
  AST_SEL_CLR: assert property (rd_go && state_ff.cls == usb_cmd_pkg::CLS_SEL_CLR
    |=> action.kind == usb_cmd_pkg::ACT_SEL_CLR_INT &&
    engine_result_byte_reg == $past(view.ep_info))
    else $error("select with clear read wrong");
  AST_EP_STATUS: assert property (acc && w_phase == usb_cmd_pkg::PH_WR && wr_ok &&
    state_ff.cls == usb_cmd_pkg::CLS_SEL_CLR |=> action.kind == usb_cmd_pkg::ACT_SET_EP_STATUS)
    else $error("endpoint status write not carried out");
  AST_VALIDATE: assert property (acc && w_phase == usb_cmd_pkg::PH_CMD &&
    w_code == usb_cmd_pkg::CODE_VALIDATE |=> action.valid &&
    action.kind == usb_cmd_pkg::ACT_VALIDATE && action.ep == selected_ep)
    else $error("validate buffer not carried out");

  COV_FRAME_TWO: cover property (rd_go && state_ff.cls == usb_cmd_pkg::CLS_FRAME ##[1:50]
    rd_go && state_ff.rd_idx == 2'h1);
  COV_SET_ADDR: cover property (action.valid && action.kind == usb_cmd_pkg::ACT_SET_ADDR);
  COV_SEL_CLR: cover property (action.valid && action.kind == usb_cmd_pkg::ACT_SEL_CLR_INT);

endmodule : usb_engine_command_port
`default_nettype wire

// *** verif/cpu_sw_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_sw_model (
  input wire logic clk_sys,
  input wire logic command_slot_free_flag,
  input wire logic result_ready_flag,
  input wire logic [7:0] engine_result_byte_reg,
  output logic cmd_word_wr,
  output logic [31:0] engine_command_word_reg,
  output logic slot_free_clr,
  output logic result_ready_clr
);
  int timeouts = 0;
  initial begin
    cmd_word_wr = 1'b0;
    engine_command_word_reg = 32'h5AA55AA5;
    slot_free_clr = 1'b0;
    result_ready_clr = 1'b0;
  end
  task automatic clr(input logic s, input logic r);
    @(negedge clk_sys);
    slot_free_clr = s;
    result_ready_clr = r;
    @(negedge clk_sys);
    slot_free_clr = 1'b0;
    result_ready_clr = 1'b0;
  endtask : clr
  // word is scrambled once released so a stale value is never taken for a new one
  task automatic issue(input logic [7:0] b, input logic [7:0] ph);
    @(negedge clk_sys);
    cmd_word_wr = 1'b1;
    engine_command_word_reg = {8'h00, b, ph, 8'h00};
    @(negedge clk_sys);
    cmd_word_wr = 1'b0;
    engine_command_word_reg = ~engine_command_word_reg;
  endtask : issue
  task automatic poll(input logic rd, output logic got);
    got = 1'b0;
    for (int i = 0; i < 16 && !got; i++) begin
      @(negedge clk_sys);
      got = rd ? (result_ready_flag === 1'b1) : (command_slot_free_flag === 1'b1);
    end
  endtask : poll
  task automatic phase(input logic [7:0] b, input logic [7:0] ph);
    logic got;
    issue(b, ph);
    poll(1'b0, got);
    if (!got) timeouts++;
    clr(1'b1, 1'b0);
  endtask : phase
  task automatic cmd(input logic [7:0] code);
    clr(1'b1, 1'b1);
    phase(code, usb_cmd_pkg::PH_CMD);
  endtask : cmd
  task automatic read(input logic [7:0] code, output logic [7:0] data, output logic got);
    issue(code, usb_cmd_pkg::PH_RD);
    poll(1'b1, got);
    data = engine_result_byte_reg;
    if (got) clr(1'b0, 1'b1);
  endtask : read
endmodule : cpu_sw_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic cmd_word_wr, slot_free_clr, result_ready_clr, command_slot_free_flag, result_ready_flag;
  logic [31:0] engine_command_word_reg;
  logic [7:0] engine_result_byte_reg, d;
  logic [4:0] selected_ep;
  logic got;
  usb_cmd_pkg::engine_view_t view = '0;
  usb_cmd_pkg::action_t act, act_q;
  int act_n = 0, err_total = 0, checked = 0, n0;
  usb_engine_command_port DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_word_wr(cmd_word_wr), .engine_command_word_reg(engine_command_word_reg),
    .slot_free_clr(slot_free_clr), .result_ready_clr(result_ready_clr), .view(view),
    .command_slot_free_flag(command_slot_free_flag), .result_ready_flag(result_ready_flag),
    .engine_result_byte_reg(engine_result_byte_reg), .action(act), .selected_ep(selected_ep));
  cpu_sw_model cpu (.clk_sys(clk_sys), .command_slot_free_flag(command_slot_free_flag),
    .result_ready_flag(result_ready_flag), .engine_result_byte_reg(engine_result_byte_reg),
    .cmd_word_wr(cmd_word_wr), .engine_command_word_reg(engine_command_word_reg),
    .slot_free_clr(slot_free_clr), .result_ready_clr(result_ready_clr));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // the action pulse lasts one cycle, so catch it here
  always @(negedge clk_sys) begin
    if (act.valid === 1'b1) begin
      act_q = act;
      act_n++;
    end
  end
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_act(input int n, input usb_cmd_pkg::act_kind_t k, input logic [4:0] ep);
    chk_byte(8'(act_n - n0), 8'(n));
    chk_byte({4'h0, act_q.kind}, {4'h0, k});
    chk_byte({3'h0, act_q.ep}, {3'h0, ep});
  endtask : chk_act
  task automatic rd_ok(input logic [7:0] code, input logic [7:0] e);
    cpu.read(code, d, got);
    chk_byte({7'h0, got}, 8'h01);
    chk_byte(d, e);
  endtask : rd_ok
  task automatic rd_refused(input logic [7:0] code);
    cpu.read(code, d, got);
    chk_byte({7'h0, got}, 8'h00);
  endtask : rd_refused
  task automatic t_dev_writes;
    logic [7:0] codes [4] = '{8'hD0, 8'hD8, 8'hF3, 8'hFE};
    for (int i = 0; i < 4; i++) begin
      n0 = act_n;
      cpu.cmd(codes[i]);
      cpu.phase(8'h3C + 8'(i), usb_cmd_pkg::PH_WR);
      chk_byte(8'(act_n - n0), 8'h01);
      chk_byte({4'h0, act_q.kind}, 8'(i + 1));
      chk_byte(act_q.data, 8'h3C + 8'(i));
      rd_refused(codes[i]);
    end
  endtask : t_dev_writes
  task automatic t_two_byte(input logic [7:0] code, input logic [15:0] v);
    cpu.cmd(code);
    rd_ok(code, v[7:0]);
    rd_ok(code, v[15:8]);
    rd_refused(code);
  endtask : t_two_byte
  task automatic t_one_byte;
    logic [7:0] codes [3] = '{8'hFE, 8'hFF, 8'hFB};
    logic [7:0] vals [3];
    vals = '{view.dev_status, view.err_code, view.err_status};
    for (int i = 0; i < 3; i++) begin
      cpu.cmd(codes[i]);
      rd_ok(codes[i], vals[i]);
      rd_refused(codes[i]);
    end
  endtask : t_one_byte
  task automatic t_select;
    n0 = act_n;
    cpu.cmd(8'h1F);
    chk_act(1, usb_cmd_pkg::ACT_SELECT, 5'h1F);
    chk_byte({3'h0, selected_ep}, 8'h1F);
    rd_refused(8'h1E);
    rd_ok(8'h1F, view.ep_info);
    n0 = act_n;
    cpu.cmd(8'h45);
    rd_ok(8'h45, view.ep_info);
    chk_act(2, usb_cmd_pkg::ACT_SEL_CLR_INT, 5'h05);
    n0 = act_n;
    cpu.cmd(8'h5F);
    cpu.phase(8'h81, usb_cmd_pkg::PH_WR);
    chk_act(2, usb_cmd_pkg::ACT_SET_EP_STATUS, 5'h1F);
    chk_byte(act_q.data, 8'h81);
  endtask : t_select
  task automatic t_buffer;
    n0 = act_n;
    cpu.cmd(8'hF2);
    chk_act(1, usb_cmd_pkg::ACT_CLR_BUF, 5'h1F);
    rd_ok(8'hF2, view.clr_buf_info);
    n0 = act_n;
    cpu.cmd(8'hFA);
    chk_act(1, usb_cmd_pkg::ACT_VALIDATE, 5'h1F);
    rd_refused(8'hFA);
  endtask : t_buffer
  // a word offered while the clock enable is low must leave no trace
  task automatic t_freeze_refuse;
    cpu.clr(1'b1, 1'b1);
    @(negedge clk_sys);
    clk_en = 1'b0;
    cpu.issue(8'hF5, usb_cmd_pkg::PH_CMD);
    repeat (3) @(negedge clk_sys);
    chk_byte({7'h0, command_slot_free_flag}, 8'h00);
    clk_en = 1'b1;
    n0 = act_n;
    cpu.cmd(8'hF5);
    cpu.phase(8'h55, usb_cmd_pkg::PH_WR);
    chk_byte(8'(act_n - n0), 8'h00);
    rd_ok(8'hF5, view.frame[7:0]);
  endtask : t_freeze_refuse
  task automatic conclude;
    err_total += cpu.timeouts;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    view = '{frame: 16'hA55A, test: 16'h3CC3, dev_status: 8'h1D, err_code: 8'h2E,
      err_status: 8'h4B, ep_info: 8'h96, clr_buf_info: 8'h69};
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk_byte({6'h0, command_slot_free_flag, result_ready_flag}, 8'h00);
    chk_byte(engine_result_byte_reg, 8'h00);
    rd_refused(8'hF5);
    t_dev_writes();
    t_two_byte(8'hF5, view.frame);
    t_two_byte(8'hFD, view.test);
    t_one_byte();
    t_select();
    t_buffer();
    t_freeze_refuse();
    conclude();
  end
endmodule : testbench
`default_nettype wire
